/* File: logic/rtc_flag_ctrl.sv */
`timescale 1ns/1ps
`include "rtc_flag_map.svh"
// Summary of operation
// - Counter count-up sets the carry flag.
// - Writing zero clears the carry flag.
// - Writing one sets the carry flag.
// - Resets initialize both enables and alarm flag.
// - Carry flag reset value undefined; software initializes. The code clears it to 0 on reset.
// - Standby leaves every register bit unchanged.
// - Flag control register: eight bits, read/write.
// - Separate interrupt enables for carry and alarm.
module rtc_flag_ctrl
  import rtc_flag_pkg::*;
(
  input  wire logic        sys_clk,      // System clock, 50 MHz.
  input  wire logic        resetn,       // Power-on or manual reset, low.
  input  wire logic        standby,      // Standby mode indication.
  input  wire logic        subsec_tick,  // Sub-second counter count-up pulse.
  input  wire logic        sec_tick,     // Seconds counter count-up pulse.
  input  wire logic        alarm_hit,    // Alarm match pulse.
  input  wire logic        hsel,         // AHB slave select.
  input  wire logic [31:0] haddr,        // AHB address.
  input  wire logic [1:0]  htrans,       // AHB transfer type.
  input  wire logic        hwrite,       // AHB write.
  input  wire logic [2:0]  hsize,        // AHB size.
  input  wire logic [31:0] hwdata,       // AHB write data.
  input  wire logic        hready,       // AHB bus ready.
  output logic      [31:0] hrdata,       // AHB read data.
  output logic             hreadyout,    // AHB slave ready.
  output logic             hresp,        // AHB response, always OKAY.
  output logic             carry_irq,    // Carry interrupt request.
  output logic             alarm_irq,    // Alarm interrupt request.
  output logic             irq           // Combined masked interrupt.
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  flag_ctrl_t                   ctrl_r;
  flag_ctrl_t                   ctrl_nxt;
  logic [`RFC_STAT_W-1:0]       stat_r;
  logic [`RFC_STAT_W-1:0]       stat_nxt;
  logic [`RFC_STAT_W-1:0]       mask_r;
  logic [`RFC_STAT_W-1:0]       mask_nxt;
  ahb_req_t                     req_r;
  logic [31:0]                  rdata_nxt;

  // Address phase capture; only whole-word transfers are decoded.
  wire        addr_take = hsel & hready & (htrans == `RFC_HTRANS_NONSEQ);
  wire [3:0]  addr_low  = haddr[`RFC_ADDR_W-1:0];
  wire        do_wr     = req_r.sel & req_r.wr;
  wire        wr_ctrl   = do_wr & (req_r.addr == `RFC_OFF_CTRL1);
  wire        wr_stat   = do_wr & (req_r.addr == `RFC_OFF_IRQ_STAT);
  wire        wr_mask   = do_wr & (req_r.addr == `RFC_OFF_IRQ_MASK);
  wire        count_up  = subsec_tick | sec_tick;
  wire [7:0]  wbyte     = hwdata[7:0];

  // Packs the control register into its byte layout.
  function automatic logic [7:0] pack_ctrl(input flag_ctrl_t c);
    logic [7:0] v;
    v = 8'h00;
    v[`RFC_BIT_CF]  = c.carry_flag;
    v[`RFC_BIT_CIE] = c.carry_irq_enable;
    v[`RFC_BIT_AIE] = c.alarm_irq_enable;
    v[`RFC_BIT_AF]  = c.alarm_flag;
    return v;
  endfunction

  // Control register update. Standby has no effect on it at all, so the
  // standby input is deliberately not used here. A count-up beats a write
  // of zero to the carry flag so no carry is ever lost.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt.carry_flag       = wbyte[`RFC_BIT_CF];
      ctrl_nxt.carry_irq_enable = wbyte[`RFC_BIT_CIE];
      ctrl_nxt.alarm_irq_enable = wbyte[`RFC_BIT_AIE];
      ctrl_nxt.alarm_flag       = wbyte[`RFC_BIT_AF];
    end
    if (count_up) begin
      ctrl_nxt.carry_flag = 1'b1;
    end
    if (alarm_hit) begin
      ctrl_nxt.alarm_flag = 1'b1;
    end
  end

  // Sticky status: write one to clear, a new event wins over the clear.
  always_comb begin
    stat_nxt = stat_r;
    if (wr_stat) begin
      stat_nxt = stat_r & ~hwdata[`RFC_STAT_W-1:0];
    end
    if (count_up) begin
      stat_nxt[`RFC_STAT_CARRY] = 1'b1;
    end
    if (alarm_hit) begin
      stat_nxt[`RFC_STAT_ALARM] = 1'b1;
    end
    mask_nxt = wr_mask ? hwdata[`RFC_STAT_W-1:0] : mask_r;
  end

  // Read mux; unmapped offsets read zero.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (addr_take && !hwrite && (hsize == `RFC_HSIZE_WORD)) begin
      case (addr_low)
        `RFC_OFF_CTRL1:    rdata_nxt = {24'h00_0000, pack_ctrl(ctrl_nxt)};
        `RFC_OFF_IRQ_STAT: rdata_nxt = {30'h0000_0000, stat_nxt};
        `RFC_OFF_IRQ_MASK: rdata_nxt = {30'h0000_0000, mask_nxt};
        default:           rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Flip-flops
  // ****************************************************************
  // The carry flag has no defined reset value in the field; it is still
  // cleared here so simulation is clean, and software must set it up.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= flag_ctrl_t'(4'h0);
      stat_r <= `RFC_STAT_RST;
      mask_r <= `RFC_MASK_RST;
      req_r  <= '0;
      hrdata <= 32'h0000_0000;
    end else begin
      ctrl_r     <= ctrl_nxt;
      stat_r     <= stat_nxt;
      mask_r     <= mask_nxt;
      req_r.sel  <= addr_take & (hsize == `RFC_HSIZE_WORD);
      req_r.wr   <= hwrite;
      req_r.addr <= addr_low;
      hrdata     <= rdata_nxt;
    end
  end

  // Interrupt outputs, registered from the next-state values so they change on the same edge as the flag.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      carry_irq <= 1'b0;
      alarm_irq <= 1'b0;
      irq       <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      carry_irq <= ctrl_nxt.carry_flag & ctrl_nxt.carry_irq_enable;
      alarm_irq <= ctrl_nxt.alarm_flag & ctrl_nxt.alarm_irq_enable;
      irq       <= |(stat_nxt & mask_nxt);
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule // rtc_flag_ctrl

/* File: logic/rtc_flag_map.svh */
`ifndef RTC_FLAG_MAP_SVH
`define RTC_FLAG_MAP_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define RFC_ADDR_W          4
`define RFC_OFF_CTRL1       4'h0
`define RFC_OFF_IRQ_STAT    4'h4
`define RFC_OFF_IRQ_MASK    4'h8
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define RFC_BIT_CF          7
`define RFC_BIT_CIE         4
`define RFC_BIT_AIE         3
`define RFC_BIT_AF          0
`define RFC_STAT_CARRY      0
`define RFC_STAT_ALARM      1
`define RFC_STAT_W          2
`define RFC_CTRL1_RST       8'h00
`define RFC_STAT_RST        2'h0
`define RFC_MASK_RST        2'h0
`define RFC_HTRANS_NONSEQ   2'h2
`define RFC_HSIZE_WORD      3'h2
`endif

/* File: logic/rtc_flag_pkg.sv */
package rtc_flag_pkg;
  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic carry_flag;
    logic carry_irq_enable;
    logic alarm_irq_enable;
    logic alarm_flag;
  } flag_ctrl_t;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [3:0] addr;
  } ahb_req_t;
endpackage

/* File: sim/rtc_flag_properties.sv */
`timescale 1ns/1ps
`include "rtc_flag_map.svh"
// ****************
// Checks at the ports
// ****************
module rtc_flag_checker (
  input wire logic        sys_clk, resetn, standby, subsec_tick, sec_tick, alarm_hit, // Inputs.
  input wire logic        hsel, hwrite, hready, hreadyout, hresp, carry_irq, alarm_irq, irq,
  input wire logic [31:0] haddr, hwdata, hrdata, // Bus words.
  input wire logic [1:0]  htrans,                // Transfer type.
  input wire logic [2:0]  hsize                  // Size.
);
  logic wa_r;
  wire  wa_nxt = hsel && hready && htrans == `RFC_HTRANS_NONSEQ && hwrite;
  wire  quiet = !hsel && !wa_r && !(subsec_tick || sec_tick || alarm_hit);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // A write's data phase is the only cause of a level change besides the event pulses.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) wa_r <= 1'b0;
    else wa_r <= wa_nxt;
  end
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("Bus stalled or errored.");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("Upper read bits set.");
  reset_quiet_a: assert property (disable iff (1'b0) !resetn |-> !carry_irq && !alarm_irq && !irq)
    else $error("Request during reset.");
  carry_rise_a: assert property ($rose(carry_irq) |-> $past(subsec_tick || sec_tick) || $past(wa_r))
    else $error("Carry request rose without cause.");
  alarm_rise_a: assert property ($rose(alarm_irq) |-> $past(alarm_hit) || $past(wa_r))
    else $error("Alarm request rose without cause.");
  carry_fall_a: assert property ($fell(carry_irq) |-> $past(wa_r))
    else $error("Carry request fell without a write.");
  carry_hold_a: assert property (carry_irq && quiet && !$past(wa_r) |=> carry_irq)
    else $error("Carry request dropped.");
  standby_keep_a: assert property (standby && quiet && !$past(wa_r) |=> $stable({alarm_irq, irq}))
    else $error("State changed in standby.");
endmodule // rtc_flag_checker
bind rtc_flag_ctrl rtc_flag_checker rtc_flag_checker_inst (.*);

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "rtc_flag_map.svh"
module tb_top;
  logic sys_clk = 0, resetn = 1, standby = 0, subsec_tick = 0, sec_tick = 0, alarm_hit = 0;
  logic hsel = 0, hwrite = 0, hreadyout, hresp, carry_irq, alarm_irq, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = `RFC_HSIZE_WORD;
  int          n_fail = 0, n_checks = 0;
  always #10 sys_clk = ~sys_clk;
  // The lone slave's ready is the bus ready.
  rtc_flag_ctrl rtc_flag_ctrl_inst (
    .sys_clk(sys_clk), .resetn(resetn), .standby(standby), .subsec_tick(subsec_tick),
    .sec_tick(sec_tick), .alarm_hit(alarm_hit), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .carry_irq(carry_irq), .alarm_irq(alarm_irq), .irq(irq));
  // Shared bus cycle, compare and event helpers.
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1;
    htrans <= `RFC_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {28'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    xfer(0, a, 0);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic lvl(input logic [2:0] e);
    repeat (2) @(posedge sys_clk);
    #1 chk({29'h0, carry_irq, alarm_irq, irq}, {29'h0, e});
  endtask
  // Event pulses last exactly one cycle, as the counters give them.
  task automatic pulse(input int k);
    @(posedge sys_clk);
    {alarm_hit, sec_tick, subsec_tick} <= 3'b1 << k;
    @(posedge sys_clk);
    {alarm_hit, sec_tick, subsec_tick} <= 3'h0;
  endtask
  task automatic t_reset;
    resetn <= 0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1;
    rdc(`RFC_OFF_CTRL1, 0);
    rdc(`RFC_OFF_IRQ_MASK, 0);
    $display("reset test done");
  endtask
  task automatic t_carry;
    xfer(1, `RFC_OFF_CTRL1, 0);
    pulse(0);
    rdc(`RFC_OFF_CTRL1, 32'h80);
    rdc(`RFC_OFF_CTRL1, 32'h80);
    xfer(1, `RFC_OFF_CTRL1, 0);
    rdc(`RFC_OFF_CTRL1, 0);
    pulse(1);
    rdc(`RFC_OFF_CTRL1, 32'h80);
    xfer(1, `RFC_OFF_CTRL1, 0);
    xfer(1, `RFC_OFF_CTRL1, 32'h90);
    rdc(`RFC_OFF_CTRL1, 32'h90);
    lvl(3'b100);
    xfer(1, `RFC_OFF_CTRL1, 32'h10);
    lvl(3'b000);
    $display("carry test done");
  endtask
  task automatic t_irq;
    xfer(1, `RFC_OFF_IRQ_STAT, 3);
    pulse(1);
    rdc(`RFC_OFF_IRQ_STAT, 1);
    xfer(1, `RFC_OFF_IRQ_MASK, 1);
    lvl(3'b101);
    xfer(1, `RFC_OFF_IRQ_MASK, 0);
    lvl(3'b100);
    xfer(1, `RFC_OFF_IRQ_STAT, 1);
    rdc(`RFC_OFF_IRQ_STAT, 0);
    xfer(1, 4'hc, 32'hff);
    rdc(4'hc, 0);
    $display("irq test done");
  endtask
  task automatic t_alarm;
    xfer(1, `RFC_OFF_CTRL1, 32'h08);
    pulse(2);
    #1 chk({31'h0, alarm_irq}, 1);
    @(posedge sys_clk);
    standby <= 1;
    repeat (20) @(posedge sys_clk);
    rdc(`RFC_OFF_CTRL1, 32'h09);
    standby <= 0;
    $display("alarm test done");
  endtask
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Tests run in order, a mid-run reset last.
  initial begin
    t_reset;
    t_carry;
    t_irq;
    t_alarm;
    t_reset;
    wrap_up;
  end
  // The tests need well under a thousand cycles; a hang is cut short here.
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_fail++;
    wrap_up;
  end
endmodule // tb_top
